// file: bmc_defs.vh
// Constants for the standby and buck mode controller: register map, field
// positions, reset values, mode codes and timing counts.
// Assumes a 200 MHz system clock and a 32.768 kHz reference derived from it.
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH

// Clock rates and derived counts.
`define BMC_CLK_HZ          200000000
`define BMC_RTC_HZ          32768
`define BMC_RTC_DIV         (`BMC_CLK_HZ / `BMC_RTC_HZ)
`define BMC_SS_TIME_US      3000
`define BMC_SS_CYCLES       ((`BMC_CLK_HZ / 1000000) * `BMC_SS_TIME_US)

// Register byte addresses.
`define BMC_ADDR_CTRL       8'h00
`define BMC_ADDR_STAT       8'h04
`define BMC_ADDR_CFG_BASE   8'h10
`define BMC_ADDR_STATE_BASE 8'h30

// Control register fields.
`define BMC_CTRL_INV        0
`define BMC_CTRL_LPSTBY     1
`define BMC_CTRL_LPOFF      2
`define BMC_CTRL_DLY_LO     3
`define BMC_CTRL_DLY_HI     4
`define BMC_CTRL_DB_LO      5
`define BMC_CTRL_DB_HI      6
`define BMC_DLY_RST         2'h1
`define BMC_DB_RST          2'h0

// Per-regulator configuration word fields.
`define BMC_CFG_MODE_LO     0
`define BMC_CFG_MODE_HI     3
`define BMC_CFG_NSP_LO      8
`define BMC_CFG_NSP_HI      12
`define BMC_CFG_SSP_LO      16
`define BMC_CFG_SSP_HI      20
`define BMC_CFG_LPM         24
`define BMC_MODE_RST        4'h0
`define BMC_SP_RST          5'h00

// Applied operating modes.
`define BMC_M_OFF           3'h0
`define BMC_M_PWM           3'h1
`define BMC_M_PULSE_SKIP         3'h2
`define BMC_M_PFM           3'h3
`define BMC_M_APS           3'h4

`define BMC_NREG            6

`endif

// file: bmc_standby_ctrl.v
// Standby qualification, low-battery debounce and buck mode control with
// an APB register slave.
// Assumes on_mode and startup_slot_load come from the power state machine
// on the same clock; standby_pin, low_battery_raw, load_high and straps
// are asynchronous.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"

module bmc_standby_ctrl
#(
	parameter RTC_DIV    = `BMC_RTC_DIV,
	parameter SS_CYCLES  = `BMC_SS_CYCLES
)
(
	// Clock and reset.
	input  wire        clock,
	input  wire        reset,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// System inputs.
	input  wire        standby_pin,
	input  wire        low_battery_raw,
	input  wire        on_mode,
	input  wire [3:0]  power_up_mode_straps,
	input  wire [5:0]  startup_slot_load,
	input  wire [5:0]  load_high,
	// Standby and supervision outputs.
	output reg         standby_active,
	output reg         low_power_standby,
	output reg         pll_enable,
	output reg         charger_detect_only,
	output reg         low_battery_det,
	// Buck regulator controls.
	output reg  [5:0]  buck_enable,
	output reg  [5:0]  buck_discharge,
	output reg  [17:0] buck_mode,
	output reg  [5:0]  buck_pwm_full,
	output reg  [29:0] buck_setpoint
);

	// Decodes a mode select code into {normal, standby} applied modes.
	function [5:0] decode_pair;
		input [3:0] code;
		begin
			case (code)
				4'h0: decode_pair = {`BMC_M_OFF, `BMC_M_OFF};
				4'h1: decode_pair = {`BMC_M_PWM, `BMC_M_OFF};
				4'h2: decode_pair = {`BMC_M_PULSE_SKIP, `BMC_M_OFF};
				4'h3: decode_pair = {`BMC_M_PFM, `BMC_M_OFF};
				4'h4: decode_pair = {`BMC_M_APS, `BMC_M_OFF};
				4'h5: decode_pair = {`BMC_M_PWM, `BMC_M_PWM};
				4'h6: decode_pair = {`BMC_M_PWM, `BMC_M_APS};
				4'h7: decode_pair = {`BMC_M_OFF, `BMC_M_OFF};
				4'h8: decode_pair = {`BMC_M_APS, `BMC_M_APS};
				4'h9: decode_pair = {`BMC_M_PWM, `BMC_M_PULSE_SKIP};
				4'hA: decode_pair = {`BMC_M_PULSE_SKIP, `BMC_M_PULSE_SKIP};
				4'hB: decode_pair = {`BMC_M_PULSE_SKIP, `BMC_M_APS};
				4'hC: decode_pair = {`BMC_M_APS, `BMC_M_PFM};
				4'hD: decode_pair = {`BMC_M_PWM, `BMC_M_PFM};
				4'hE: decode_pair = {`BMC_M_PULSE_SKIP, `BMC_M_PFM};
				4'hF: decode_pair = {`BMC_M_PFM, `BMC_M_PFM};
				default: decode_pair = {`BMC_M_OFF, `BMC_M_OFF};
			endcase
		end
	endfunction

	// Debounce length in reference ticks for the low battery field.
	function [3:0] db_limit;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: db_limit = 4'h0;
				2'h1: db_limit = 4'h2;
				2'h2: db_limit = 4'h4;
				2'h3: db_limit = 4'h8;
				default: db_limit = 4'h0;
			endcase
		end
	endfunction

	// Bus decode. Writes take effect on the edge that completes the access,
	// when the registered ready is seen high; read data is registered one edge earlier.
	wire        acc_first  = psel & penable & ~pready;
	wire        acc_done   = psel & penable & pready;
	wire        wr_done    = acc_done & pwrite;
	wire        wr_ctrl    = wr_done & (paddr == `BMC_ADDR_CTRL);

	// Control register.
	reg         inv_q;
	reg         lpstby_q;
	reg         lpoff_req_q;
	reg  [1:0]  dly_sel_q;
	reg  [1:0]  db_sel_q;

	// Reference tick from the system clock.
	reg  [31:0] div_q;
	reg         tick_q;

	// Synchronisers.
	reg         stby_s1_q;
	reg         stby_s2_q;
	reg         batt_s1_q;
	reg         batt_s2_q;
	reg  [3:0]  strap_s1_q;
	reg  [3:0]  strap_s2_q;
	reg  [5:0]  load_s1_q;
	reg  [5:0]  load_s2_q;

	// Standby qualification and low battery debounce.
	reg  [1:0]  dly_cnt_q;
	reg         stby_prev_q;
	reg  [3:0]  db_cnt_q;

	wire        stby_eff   = stby_s2_q ^ inv_q;
	wire        stby_gated = stby_eff & on_mode;
	wire        any_load   = |startup_slot_load;
	wire        stby_chg   = stby_prev_q ^ standby_active;

	always @(posedge clock)
	begin
		if (reset)
		begin
			inv_q       <= 1'b0;
			lpstby_q    <= 1'b0;
			lpoff_req_q <= 1'b0;
			dly_sel_q   <= `BMC_DLY_RST;
			db_sel_q    <= `BMC_DB_RST;
		end
		else
		begin
			if (wr_ctrl)
			begin
				inv_q     <= pwdata[`BMC_CTRL_INV];
				lpstby_q  <= pwdata[`BMC_CTRL_LPSTBY];
				dly_sel_q <= pwdata[`BMC_CTRL_DLY_HI:`BMC_CTRL_DLY_LO];
				db_sel_q  <= pwdata[`BMC_CTRL_DB_HI:`BMC_CTRL_DB_LO];
			end
			// A software set in the same cycle as a startup clear wins.
			if (wr_ctrl && pwdata[`BMC_CTRL_LPOFF])
				lpoff_req_q <= 1'b1;
			else if (any_load)
				lpoff_req_q <= 1'b0;
			else if (wr_ctrl)
				lpoff_req_q <= 1'b0;
		end
	end

	always @(posedge clock)
	begin
		if (reset)
		begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b0;
		end
		else if (div_q == RTC_DIV - 1)
		begin
			div_q  <= 32'h00000000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q  <= div_q + 32'h00000001;
			tick_q <= 1'b0;
		end
	end

	always @(posedge clock)
	begin
		if (reset)
		begin
			stby_s1_q  <= 1'b0;
			stby_s2_q  <= 1'b0;
			batt_s1_q  <= 1'b0;
			batt_s2_q  <= 1'b0;
			strap_s1_q <= 4'h0;
			strap_s2_q <= 4'h0;
			load_s1_q  <= 6'h00;
			load_s2_q  <= 6'h00;
		end
		else
		begin
			stby_s1_q  <= standby_pin;
			stby_s2_q  <= stby_s1_q;
			batt_s1_q  <= low_battery_raw;
			batt_s2_q  <= batt_s1_q;
			strap_s1_q <= power_up_mode_straps;
			strap_s2_q <= strap_s1_q;
			load_s1_q  <= load_high;
			load_s2_q  <= load_s1_q;
		end
	end

	// Entry waits for the programmed number of ticks; exit is at once.
	always @(posedge clock)
	begin
		if (reset)
		begin
			dly_cnt_q           <= 2'h0;
			standby_active      <= 1'b0;
			stby_prev_q         <= 1'b0;
			low_power_standby   <= 1'b0;
			pll_enable          <= 1'b1;
			charger_detect_only <= 1'b0;
		end
		else
		begin
			stby_prev_q <= standby_active;
			if (!stby_gated)
			begin
				dly_cnt_q      <= 2'h0;
				standby_active <= 1'b0;
			end
			else if (!standby_active)
			begin
				if (dly_cnt_q == dly_sel_q)
					standby_active <= 1'b1;
				else if (tick_q)
					dly_cnt_q <= dly_cnt_q + 2'h1;
			end
			low_power_standby   <= standby_active & lpstby_q;
			pll_enable          <= ~(standby_active & lpstby_q);
			charger_detect_only <= standby_active & lpstby_q;
		end
	end

	// Low battery debounce: the new level must hold for the full count.
	always @(posedge clock)
	begin
		if (reset)
		begin
			db_cnt_q        <= 4'h0;
			low_battery_det <= 1'b0;
		end
		else if (batt_s2_q == low_battery_det)
			db_cnt_q <= 4'h0;
		else if (db_limit(db_sel_q) == 4'h0)
			low_battery_det <= batt_s2_q;
		else if (tick_q)
		begin
			if (db_cnt_q == db_limit(db_sel_q) - 4'h1)
			begin
				low_battery_det <= batt_s2_q;
				db_cnt_q        <= 4'h0;
			end
			else
				db_cnt_q <= db_cnt_q + 4'h1;
		end
	end

	// Per-regulator configuration words and applied state for the read mux.
	wire [32*`BMC_NREG-1:0] cfg_flat;
	wire [32*`BMC_NREG-1:0] state_flat;

	genvar gi;
	generate
		for (gi = 0; gi < `BMC_NREG; gi = gi + 1)
		begin : g_reg
			localparam [31:0] CFG_A = `BMC_ADDR_CFG_BASE + gi * 4;
			wire        wr_i = wr_done & (paddr == CFG_A[7:0]);
			reg  [3:0]  msel_q;
			reg  [4:0]  nsp_q;
			reg  [4:0]  ssp_q;
			reg         lpm_q;
			reg         lpo_q;
			reg  [31:0] ss_cnt_q;
			reg         ss_aps_q;
			reg         act_q;
			reg  [4:0]  cur_sp_q;
			wire [5:0]  pair = decode_pair(msel_q);
			wire [2:0]  tgt_mode = lpo_q ? (lpm_q ? `BMC_M_PFM : `BMC_M_OFF)
				: (standby_active ? pair[2:0] : pair[5:3]);
			wire [4:0]  tgt_sp = (lpo_q | standby_active) ? ssp_q : nsp_q;
			wire        active = (tgt_mode != `BMC_M_OFF);
			wire [2:0]  app_mode = (ss_cnt_q != 32'h00000000) ? `BMC_M_PWM
				: (ss_aps_q ? `BMC_M_APS : tgt_mode);

			always @(posedge clock)
			begin
				if (reset)
				begin
					msel_q <= `BMC_MODE_RST;
					nsp_q  <= `BMC_SP_RST;
					ssp_q  <= `BMC_SP_RST;
					lpm_q  <= 1'b0;
				end
				else if (startup_slot_load[gi])
				begin
					msel_q <= strap_s2_q;
					nsp_q  <= {1'b1, strap_s2_q};
					ssp_q  <= {1'b1, strap_s2_q};
				end
				else if (wr_i)
				begin
					msel_q <= pwdata[`BMC_CFG_MODE_HI:`BMC_CFG_MODE_LO];
					nsp_q  <= pwdata[`BMC_CFG_NSP_HI:`BMC_CFG_NSP_LO];
					ssp_q  <= pwdata[`BMC_CFG_SSP_HI:`BMC_CFG_SSP_LO];
					lpm_q  <= pwdata[`BMC_CFG_LPM];
				end
			end

			// A regulator held by low power off stays so until its own slot.
			always @(posedge clock)
			begin
				if (reset)
					lpo_q <= 1'b0;
				else if (startup_slot_load[gi])
					lpo_q <= 1'b0;
				else if (lpoff_req_q)
					lpo_q <= 1'b1;
			end

			always @(posedge clock)
			begin
				if (reset)
				begin
					act_q    <= 1'b0;
					ss_cnt_q <= 32'h00000000;
					ss_aps_q <= 1'b0;
					cur_sp_q <= `BMC_SP_RST;
				end
				else if (!active)
				begin
					act_q    <= 1'b0;
					ss_cnt_q <= 32'h00000000;
					ss_aps_q <= 1'b0;
					cur_sp_q <= `BMC_SP_RST;
				end
				else
				begin
					act_q <= 1'b1;
					if (!act_q)
						ss_cnt_q <= SS_CYCLES;
					else if (ss_cnt_q != 32'h00000000)
						ss_cnt_q <= ss_cnt_q - 32'h00000001;
					if (act_q && ss_cnt_q == 32'h00000001)
						ss_aps_q <= 1'b1;
					else if (wr_i || stby_chg || lpo_q)
						ss_aps_q <= 1'b0;
					// One step per tick keeps the slope controlled.
					if (tick_q && cur_sp_q < tgt_sp)
						cur_sp_q <= cur_sp_q + 5'h01;
					else if (tick_q && cur_sp_q > tgt_sp)
						cur_sp_q <= cur_sp_q - 5'h01;
				end
			end

			always @(posedge clock)
			begin
				if (reset)
				begin
					buck_enable[gi]          <= 1'b0;
					buck_discharge[gi]       <= 1'b1;
					buck_mode[3*gi+2:3*gi]   <= `BMC_M_OFF;
					buck_pwm_full[gi]        <= 1'b0;
					buck_setpoint[5*gi+4:5*gi] <= `BMC_SP_RST;
				end
				else
				begin
					buck_enable[gi]          <= active & act_q;
					buck_discharge[gi]       <= ~active;
					buck_mode[3*gi+2:3*gi]   <= (active & act_q) ? app_mode : `BMC_M_OFF;
					buck_pwm_full[gi]        <= (app_mode == `BMC_M_PWM)
						| ((app_mode == `BMC_M_APS) & load_s2_q[gi]);
					buck_setpoint[5*gi+4:5*gi] <= cur_sp_q;
				end
			end

			// The configuration word reads back what software wrote or the startup slot loaded.
			assign cfg_flat[32*gi+31:32*gi] = {7'h00, lpm_q, 3'h0, ssp_q, 3'h0, nsp_q,
				4'h0, msel_q};
			assign state_flat[32*gi+31:32*gi] = {19'h00000, cur_sp_q, 5'h00, app_mode};
		end
	endgenerate

	// Read mux and unmapped address detection.
	reg  [31:0] rdata_d;
	reg         err_d;
	integer     k;
	always @*
	begin
		rdata_d = 32'h00000000;
		err_d   = 1'b1;
		if (paddr == `BMC_ADDR_CTRL)
		begin
			rdata_d = {25'h0000000, db_sel_q, dly_sel_q, lpoff_req_q, lpstby_q, inv_q};
			err_d   = 1'b0;
		end
		else if (paddr == `BMC_ADDR_STAT)
		begin
			rdata_d = {26'h0000000, low_battery_det, pll_enable, low_power_standby,
				standby_active, stby_eff, stby_s2_q};
			err_d   = 1'b0;
		end
		for (k = 0; k < `BMC_NREG; k = k + 1)
		begin
			if (paddr == `BMC_ADDR_CFG_BASE + k[7:0] * 8'h04)
			begin
				rdata_d = cfg_flat[32*k +: 32];
				err_d   = 1'b0;
			end
			if (paddr == `BMC_ADDR_STATE_BASE + k[7:0] * 8'h04)
			begin
				rdata_d = state_flat[32*k +: 32];
				err_d   = 1'b0;
			end
		end
	end

	// Ready rises in the second access cycle, so every access takes two.
	always @(posedge clock)
	begin
		if (reset)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc_first;
			pslverr <= acc_first & err_d;
			if (acc_first & ~pwrite)
				prdata <= rdata_d;
		end
	end

endmodule
`default_nettype wire

// file: bmc_sva.sv
// Concurrent checks on the standby and buck mode controller ports.
// Assumes it is bound to the controller top and shares its header.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"
module bmc_sva (
	// Clock and reset.
	input	wire logic		clock,
	input	wire logic		reset,
	// Standby side.
	input	wire logic		standby_pin,
	input	wire logic		on_mode,
	input	wire logic		standby_active,
	input	wire logic		low_power_standby,
	input	wire logic		pll_enable,
	input	wire logic		charger_detect_only,
	// Regulator side.
	input	wire logic [5:0]	buck_enable,
	input	wire logic [5:0]	buck_discharge,
	input	wire logic [17:0]	buck_mode,
	input	wire logic [5:0]	buck_pwm_full,
	input	wire logic [29:0]	buck_setpoint
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);

	AST_PLL_OFF: assert property (pll_enable != low_power_standby)
		else $error("pll enable does not mirror low power standby");
	AST_CHG_ONLY: assert property (charger_detect_only == low_power_standby)
		else $error("charger only detection differs from low power standby");
	AST_LPS_NEEDS_SB: assert property (!standby_active |=> !low_power_standby)
		else $error("low power standby without standby");
	AST_OFF_MODE: assert property (!on_mode |=> !standby_active)
		else $error("standby active outside on mode");
	// Two synchroniser stages mean a pin edge cannot reach the output sooner.
	AST_SYNC_DELAY: assert property ($changed(standby_pin) && on_mode |=> $stable(standby_active) [*2])
		else $error("standby pin reached standby output too early");
	AST_DISCHARGE: assert property (buck_discharge[0] [*2] |-> !buck_enable[0] && buck_setpoint[4:0] == 5'h00)
		else $error("off regulator still enabled or holding a set point");
	AST_SOFT_PWM: assert property ($rose(buck_enable[0]) |-> ##[0:2] (buck_mode[2:0] == `BMC_M_PWM) [*8])
		else $error("activation not forced into pwm");
	AST_PWM_FULL: assert property ((buck_mode[2:0] == `BMC_M_PWM) [*2] |-> buck_pwm_full[0])
		else $error("pwm mode without full pwm");
	AST_RAMP: assert property (buck_enable[0] && $past(buck_enable[0]) |->
		buck_setpoint[4:0] == $past(buck_setpoint[4:0]) || buck_setpoint[4:0] == $past(buck_setpoint[4:0]) + 5'h01
		|| buck_setpoint[4:0] == $past(buck_setpoint[4:0]) - 5'h01)
		else $error("set point moved by more than one step");

	COV_SB: cover property ($rose(standby_active));
	COV_LPS: cover property ($rose(low_power_standby));
	COV_EN: cover property ($rose(buck_enable[0]));
endmodule
`default_nettype wire

// file: bmc_host.sv
// Host processor model that drives the standby pin.
// Assumes the bench gives the wanted level; the pin follows after an edge.
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
	// Clock.
	input	wire logic	clock,
	// Wanted standby level.
	input	wire logic	want_standby,
	// Pin toward the device.
	output	var logic	standby_pin
);
	// The pin has this single driver; it settles at the first edge, while reset is held.
	// The host runs on the controller clock, so the pin only moves just after an edge.
	always @(posedge clock)
		standby_pin <= want_standby;
endmodule
`default_nettype wire

// file: standby_buck_mode_control_tb_top.sv
// Self-checking bench for the standby and buck mode controller.
// Assumes the controller header and short tick and soft start counts.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"
module standby_buck_mode_control_tb_top;
	localparam int DIV = 8;
	localparam int SS = 50;
	// Normal and standby decode, one nibble per mode code.
	localparam logic [63:0] NRM = 64'h3214_2214_0114_3210;
	localparam logic [63:0] SBY = 64'h3333_4224_0410_0000;
	logic		clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0, prdata, rd;
	logic		pready, pslverr, err, want_standby = 1'b0, standby_pin;
	logic		low_battery_raw = 1'b0, on_mode = 1'b0;
	logic [3:0]	power_up_mode_straps = 4'h5;
	logic [5:0]	startup_slot_load = 6'h00, load_high = 6'h00;
	logic		standby_active, low_power_standby, pll_enable, charger_detect_only, low_battery_det;
	logic [5:0]	buck_enable, buck_discharge, buck_pwm_full;
	logic [17:0]	buck_mode;
	logic [29:0]	buck_setpoint;
	int		num_errors = 0, checked = 0;
	wire [1:0]	watch = {low_battery_det, standby_active};

	always #2.5 clock = ~clock;
	bmc_standby_ctrl #(.RTC_DIV(DIV), .SS_CYCLES(SS)) dut_u (
		.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby_pin(standby_pin), .low_battery_raw(low_battery_raw), .on_mode(on_mode),
		.power_up_mode_straps(power_up_mode_straps), .startup_slot_load(startup_slot_load),
		.load_high(load_high), .standby_active(standby_active), .low_power_standby(low_power_standby),
		.pll_enable(pll_enable), .charger_detect_only(charger_detect_only),
		.low_battery_det(low_battery_det), .buck_enable(buck_enable), .buck_discharge(buck_discharge),
		.buck_mode(buck_mode), .buck_pwm_full(buck_pwm_full), .buck_setpoint(buck_setpoint));
	bmc_host host_u (.clock(clock), .want_standby(want_standby), .standby_pin(standby_pin));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Waits for ready without its own limit; only the watchdog ends a hung access.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task lat(input int i, input logic v, output int n);
		n = 0;
		while (watch[i] !== v && n < 500)
		begin
			@(posedge clock);
			n++;
		end
	endtask

	task t_regs;
		apb(1'b0, `BMC_ADDR_CTRL, 32'h0);
		chk(rd, 32'h0000_0008);
		apb(1'b0, `BMC_ADDR_STAT, 32'h0);
		chk(rd, 32'h0000_0010);
		apb(1'b0, 8'h08, 32'h0);
		chk(32'(err), 32'h1);
		$display("register defaults done");
	endtask

	task t_db;
		int n;
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, `BMC_ADDR_CTRL, 32'(k << 5));
			low_battery_raw <= 1'b1;
			lat(1, 1'b1, n);
			chk(32'(n >= (k == 0 ? 1 : ((1 << k) - 1) * DIV) && n <= (k == 0 ? 0 : 1 << k) * DIV + 6), 32'h1);
			low_battery_raw <= 1'b0;
			lat(1, 1'b0, n);
			chk(32'(low_battery_det), 32'h0);
		end
		$display("debounce done");
	endtask

	task t_sb;
		int n;
		for (int d = 0; d < 4; d++)
		begin
			apb(1'b1, `BMC_ADDR_CTRL, 32'(d << 3) | 32'h2);
			want_standby <= 1'b1;
			lat(0, 1'b1, n);
			chk(32'(n >= (d > 1 ? d - 1 : 0) * DIV + 4 && n <= d * DIV + 5), 32'h1);
			repeat (2) @(posedge clock);
			chk({29'h0, low_power_standby, pll_enable, charger_detect_only}, 32'h5);
			want_standby <= 1'b0;
			lat(0, 1'b0, n);
			chk(32'(n >= 4 && n <= 5), 32'h1);
			repeat (2) @(posedge clock);
		end
		apb(1'b1, `BMC_ADDR_CTRL, 32'h1);
		repeat (4) @(posedge clock);
		chk(32'(standby_active), 32'h1);
		apb(1'b1, `BMC_ADDR_CTRL, 32'h0);
		on_mode <= 1'b0;
		want_standby <= 1'b1;
		repeat (4 * DIV) @(posedge clock);
		chk(32'(standby_active), 32'h0);
		on_mode <= 1'b1;
		repeat (6) @(posedge clock);
		chk(32'(standby_active), 32'h1);
		want_standby <= 1'b0;
		repeat (8) @(posedge clock);
		$display("standby timing done");
	endtask

	// Each code starts from off so that the soft start is seen for every code that does not decode to off.
	task t_modes(input logic sb);
		logic [2:0] e;
		load_high <= {5'h00, ~sb};
		for (int c = 0; c < 16; c++)
		begin
			e = sb ? 3'(SBY >> (4 * c)) : 3'(NRM >> (4 * c));
			apb(1'b1, `BMC_ADDR_CFG_BASE, 32'h0);
			repeat (4) @(posedge clock);
			apb(1'b1, `BMC_ADDR_CFG_BASE, 32'(c));
			repeat (SS + 8) @(posedge clock);
			apb(1'b0, `BMC_ADDR_STATE_BASE, 32'h0);
			chk(32'(rd[2:0]), (e == 3'h0) ? 32'h0 : 32'h4);
			apb(1'b1, `BMC_ADDR_CFG_BASE, 32'(c));
			repeat (4) @(posedge clock);
			apb(1'b0, `BMC_ADDR_STATE_BASE, 32'h0);
			chk(32'(rd[2:0]), 32'(e));
			chk(32'(buck_discharge[0]), 32'(e == 3'h0));
			chk(32'(buck_enable[0]), 32'(e != 3'h0));
			chk(32'(buck_mode[2:0]), 32'(e));
			chk(32'(buck_pwm_full[0]), 32'(e == 3'h1 || (e == 3'h4 && !sb)));
			apb(1'b0, `BMC_ADDR_CFG_BASE, 32'h0);
			chk(rd, 32'(c));
		end
		$display("mode table done, standby %0d", sb);
	endtask

	task t_lpo;
		want_standby <= 1'b0;
		apb(1'b1, `BMC_ADDR_CFG_BASE, 32'h0114_0301);
		repeat (100) @(posedge clock);
		apb(1'b1, `BMC_ADDR_CTRL, 32'h4);
		apb(1'b0, `BMC_ADDR_STATE_BASE, 32'h0);
		chk(32'(rd[12:8] < 5'h14 && rd[2:0] == 3'h3), 32'h1);
		want_standby <= 1'b1;
		repeat (300) @(posedge clock);
		apb(1'b0, `BMC_ADDR_STATE_BASE, 32'h0);
		chk(rd & 32'h1F07, 32'h1403);
		chk(32'(buck_setpoint[4:0]), 32'h14);
		power_up_mode_straps <= 4'hA;
		repeat (4) @(posedge clock);
		startup_slot_load <= 6'h01;
		@(posedge clock);
		startup_slot_load <= 6'h00;
		repeat (2) @(posedge clock);
		apb(1'b0, `BMC_ADDR_CFG_BASE, 32'h0);
		chk(rd & 32'h001F_1F0F, 32'h001A_1A0A);
		apb(1'b0, `BMC_ADDR_CTRL, 32'h0);
		chk(rd & 32'h4, 32'h0);
		$display("low power off done");
	endtask

	task wrap_up;
		$display("checked %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		on_mode <= 1'b1;
		@(posedge clock);
		t_regs;
		t_db;
		t_sb;
		t_modes(1'b0);
		want_standby <= 1'b1;
		repeat (10) @(posedge clock);
		t_modes(1'b1);
		t_lpo;
		wrap_up;
	end

	initial
	begin
		#100000;
		num_errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up;
	end
endmodule
bind bmc_standby_ctrl bmc_sva chk_u (
	.clock(clock), .reset(reset), .standby_pin(standby_pin), .on_mode(on_mode),
	.standby_active(standby_active), .low_power_standby(low_power_standby), .pll_enable(pll_enable),
	.charger_detect_only(charger_detect_only), .buck_enable(buck_enable),
	.buck_discharge(buck_discharge), .buck_mode(buck_mode), .buck_pwm_full(buck_pwm_full),
	.buck_setpoint(buck_setpoint));
`default_nettype wire
